// *** mpc_top.sv ***
// management port control register and its frame gating
// Operation
// [RULE1] stp field bits 7:5 decodes none, disabled, blocking, listening, learning, forwarding
// [RULE2] host writes its computed spanning tree state into the field
// [RULE3] stp field ignored while forwarding mode select says unmanaged
// [RULE4] unicast accept set: flooded unicast delivered to frame management port
// [RULE5] unicast accept clear: only mirrored unicast frames go to that port
// [RULE6] multicast accept set: flooded multicast delivered to frame management port
// [RULE7] multicast accept clear: only mirrored multicast frames go to that port
// [RULE8] broadcast accept set: broadcast delivered, no lookup failure needed
// [RULE9] broadcast accept clear: only mirrored broadcast frames go to that port
// [RULE10] the three accept bits ignored unless port is frame management port
// [RULE11] transmit off disables mac transmit, with flush mode also at 0x02
// [RULE12] receive off disables mac receive
// [RULE13] stp field resets to 001 managed, 000 unmanaged, by strap pin
// [RULE14] forwarding mode select loads inverse of strap at reset, software may rewrite
// assumes synchronous reset RESET_N and apb master on MCLK; strap stable at reset
`timescale 1ns/1ps
`include "mpc_map.svh"
module mpc_top (
  input  wire logic        MCLK,           // 50 MHz core clock
  input  wire logic        RESET_N,        // sync reset, active low
  input  wire logic        PSEL,           // apb select
  input  wire logic        PENABLE,        // apb access phase
  input  wire logic        PWRITE,         // apb direction
  input  wire logic [7:0]  PADDR,          // apb byte address
  input  wire logic [31:0] PWDATA,         // apb write data
  output logic      [31:0] PRDATA,         // apb read data
  output logic             PREADY,         // apb ready
  output logic             PSLVERR,        // apb error, unmapped address
  input  wire logic        FORWARDING_STRAP_PIN, // strap, high selects unmanaged
  input  wire logic        FRM_VALID,      // candidate frame present
  input  wire logic        FRM_UCST,       // frame is unicast
  input  wire logic        FRM_MCST,       // frame is multicast
  input  wire logic        FRM_BCST,       // frame is broadcast
  input  wire logic        FRM_FLOOD,      // address lookup failed
  input  wire logic        FRM_MIRROR,     // mirror rules matched
  output logic             FRM_DELIVER,    // admit frame to the port
  output logic [2:0]       SPANNING_TREE_STATE_EFF,  // effective spanning tree state
  output logic             MAC_TX_EN,      // mac transmit allowed
  output logic             MAC_RX_EN       // mac receive allowed
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    mpc_pkg::mpc_cfg_s cfg;
    logic              strap_pend;
    logic [31:0]       prdata;
    logic              pslverr;
  } mpc_top_s;

  mpc_top_s st;
  mpc_top_s next_st;

  logic              wr_ctrl;
  logic              wr_mode;
  logic              wr_stat;
  logic              rd_hit;
  logic              bad_addr;
  logic              deliver;
  mpc_pkg::mpc_stp_e stp_eff;
  logic              tx_en;
  logic              rx_en;

  mpc_cfg_if cfg_bus ();

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  mpc_apb u_apb (
    .clk      (MCLK),
    .rst_n    (RESET_N),
    .psel     (PSEL),
    .penable  (PENABLE),
    .pwrite   (PWRITE),
    .paddr    (PADDR),
    .wr_ctrl  (wr_ctrl),
    .wr_mode  (wr_mode),
    .wr_stat  (wr_stat),
    .rd_hit   (rd_hit),
    .bad_addr (bad_addr)
  );

  // control word image as software sees it
  function automatic logic [7:0] ctrl_image(input mpc_pkg::mpc_cfg_s c);
    ctrl_image = {c.stp, c.ucst, c.mcst, c.bcst, c.tx_off, c.rx_off};
  endfunction

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    // strap is caught on the first clocked cycle after reset release,
    // so the reset branch loads only constants
    if (st.strap_pend) begin
      next_st.strap_pend   = 1'b0;
      next_st.cfg.fwd_mode = !FORWARDING_STRAP_PIN;                  // see [RULE14]
      next_st.cfg.stp      = FORWARDING_STRAP_PIN ? `MPC_STP_RST_UNMGD
                                                  : `MPC_STP_RST_MGD; // see [RULE13]
    end
    // software writes take effect in the access cycle; they win over the strap
    if (wr_ctrl) begin
      next_st.cfg.stp    = PWDATA[`MPC_STP_HI:`MPC_STP_LO];          // see [RULE2]
      next_st.cfg.ucst   = PWDATA[`MPC_BIT_UCST];
      next_st.cfg.mcst   = PWDATA[`MPC_BIT_MCST];
      next_st.cfg.bcst   = PWDATA[`MPC_BIT_BCST];
      next_st.cfg.tx_off = PWDATA[`MPC_BIT_TXOFF];                   // see [RULE11]
      next_st.cfg.rx_off = PWDATA[`MPC_BIT_RXOFF];                   // see [RULE12]
    end
    if (wr_mode) begin
      next_st.cfg.fwd_mode = PWDATA[`MPC_BIT_FWD_MODE];              // see [RULE14]
      next_st.cfg.mgmt_sel = PWDATA[`MPC_BIT_MGMT_SEL];
    end
    if (wr_stat) begin
      next_st.cfg.flush_mode = PWDATA[7:0];
    end
    // read data registered in setup so it stands for the access cycle only;
    // any other edge clears it, so idle cycles never show a stale word
    next_st.prdata  = 32'h0000_0000;
    next_st.pslverr = 1'b0;
    if (PSEL && !PENABLE) begin
      next_st.pslverr = bad_addr;
      if (rd_hit) begin
        case (PADDR)
          `MPC_OFF_CTRL: next_st.prdata = {24'h00_0000, ctrl_image(st.cfg)};
          `MPC_OFF_MODE: next_st.prdata = {30'h0000_0000, st.cfg.mgmt_sel,
                                           st.cfg.fwd_mode};
          `MPC_OFF_STATUS: next_st.prdata = {24'h00_0000, st.cfg.flush_mode};
          default: next_st.prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // state register; only constants under reset
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      st.cfg.stp        <= `MPC_STP_RST_MGD;
      st.cfg.ucst       <= `MPC_RST_FLAG;                            // see [RULE4]
      st.cfg.mcst       <= `MPC_RST_FLAG;                            // see [RULE6]
      st.cfg.bcst       <= `MPC_RST_FLAG;                            // see [RULE8]
      st.cfg.tx_off     <= `MPC_RST_FLAG;
      st.cfg.rx_off     <= `MPC_RST_FLAG;
      st.cfg.fwd_mode   <= 1'b1;
      st.cfg.mgmt_sel   <= 1'b0;
      st.cfg.flush_mode <= 8'h00;
      st.strap_pend     <= 1'b1;
      st.prdata         <= 32'h0000_0000;
      st.pslverr        <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign cfg_bus.cfg = st.cfg;

  // ----------------------------------------------------------------------
  // frame gating and mac enables
  // ----------------------------------------------------------------------
  mpc_gate u_gate (
    .clk        (MCLK),
    .rst_n      (RESET_N),
    .cfgp       (cfg_bus),
    .frm_valid  (FRM_VALID),
    .frm_ucst   (FRM_UCST),
    .frm_mcst   (FRM_MCST),
    .frm_bcst   (FRM_BCST),
    .frm_flood  (FRM_FLOOD),
    .frm_mirror (FRM_MIRROR),
    .deliver    (deliver),
    .stp_eff    (stp_eff),
    .tx_en      (tx_en),
    .rx_en      (rx_en)
  );

  // outputs straight from flip-flops except PREADY, tied high
  assign PRDATA        = st.prdata;
  assign PSLVERR       = st.pslverr;
  assign PREADY        = 1'b1;   // zero wait states; constant, no state to hold
  assign FRM_DELIVER   = deliver;
  assign SPANNING_TREE_STATE_EFF = stp_eff;
  assign MAC_TX_EN     = tx_en;
  assign MAC_RX_EN     = rx_en;

endmodule

// *** mpc_map.svh ***
// register map and field constants for the management port control block
// assumes inclusion by the modules that decode these fields
`ifndef MPC_MAP_SVH
`define MPC_MAP_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses on the apb word bus)
// ----------------------------------------------------------------------
`define MPC_OFF_CTRL        8'h10
`define MPC_OFF_MODE        8'h14
`define MPC_OFF_STATUS      8'h18

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define MPC_STP_HI          7
`define MPC_STP_LO          5
`define MPC_BIT_UCST        4
`define MPC_BIT_MCST        3
`define MPC_BIT_BCST        2
`define MPC_BIT_TXOFF       1
`define MPC_BIT_RXOFF       0
`define MPC_RST_FLAG        1'h0
`define MPC_STP_RST_MGD     3'h1
`define MPC_STP_RST_UNMGD   3'h0
`define MPC_FLUSH_STOP      8'h02

// ----------------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------------
`define MPC_BIT_FWD_MODE    0
`define MPC_BIT_MGMT_SEL    1

`endif

// *** mpc_pkg.sv ***
// types shared by the management port control block
// assumes mpc_map.svh is on the include path
package mpc_pkg;

  // decoded spanning tree state of the management port
  typedef enum logic [2:0] {
    MPC_STP_NONE,
    MPC_STP_DISABLED,
    MPC_STP_BLOCKING,
    MPC_STP_LISTENING,
    MPC_STP_LEARNING,
    MPC_STP_FORWARDING,
    MPC_STP_RESERVED
  } mpc_stp_e;

  // register contents handed from the register file to the gating logic
  typedef struct packed {
    logic [2:0] stp;
    logic       ucst;
    logic       mcst;
    logic       bcst;
    logic       tx_off;
    logic       rx_off;
    logic       fwd_mode;
    logic       mgmt_sel;
    logic [7:0] flush_mode;
  } mpc_cfg_s;

endpackage

// *** mpc_cfg_if.sv ***
// carries register settings from the register file to the gating logic
// assumes one clock domain; no handshake, levels only
`timescale 1ns/1ps
interface mpc_cfg_if;
  mpc_pkg::mpc_cfg_s cfg;   // current settings

  modport src (output cfg);
  modport dst (input  cfg);
endinterface

// *** mpc_gate.sv ***
// gating of flooded frames, spanning tree decode and mac enables
// assumes frame qualifiers are one-cycle-aligned levels from the switch core
`timescale 1ns/1ps
`include "mpc_map.svh"
module mpc_gate (
  input  wire logic        clk,          // core clock
  input  wire logic        rst_n,        // sync reset, active low
  mpc_cfg_if.dst           cfgp,         // register settings
  input  wire logic        frm_valid,    // candidate frame for the port
  input  wire logic        frm_ucst,     // frame is unicast
  input  wire logic        frm_mcst,     // frame is multicast
  input  wire logic        frm_bcst,     // frame is broadcast
  input  wire logic        frm_flood,    // address lookup failed
  input  wire logic        frm_mirror,   // mirror rules matched
  output logic             deliver,      // admit the frame
  output mpc_pkg::mpc_stp_e stp_eff,     // effective spanning tree state
  output logic             tx_en,        // mac transmit allowed
  output logic             rx_en         // mac receive allowed
);

  typedef struct packed {
    logic              deliver;
    mpc_pkg::mpc_stp_e stp_eff;
    logic              tx_en;
    logic              rx_en;
  } mpc_gate_s;

  mpc_gate_s st;
  mpc_gate_s next_st;

  // code to state; reserved codes kept distinct so the core can block them
  function automatic mpc_pkg::mpc_stp_e stp_decode(input logic [2:0] code);
    case (code)
      3'h0: stp_decode = mpc_pkg::MPC_STP_NONE;
      3'h1: stp_decode = mpc_pkg::MPC_STP_DISABLED;
      3'h2: stp_decode = mpc_pkg::MPC_STP_BLOCKING;
      3'h3: stp_decode = mpc_pkg::MPC_STP_LISTENING;
      3'h4: stp_decode = mpc_pkg::MPC_STP_LEARNING;
      3'h5: stp_decode = mpc_pkg::MPC_STP_FORWARDING;
      default: stp_decode = mpc_pkg::MPC_STP_RESERVED;
    endcase
  endfunction

  // next-state logic
  always_comb begin
    logic flood_ok;
    flood_ok = 1'b0;
    next_st  = st;
    // unmanaged mode: field ignored, port behaves as without spanning tree
    if (!cfgp.cfg.fwd_mode) begin
      next_st.stp_eff = mpc_pkg::MPC_STP_NONE;                       // see [RULE3]
    end else begin
      next_st.stp_eff = stp_decode(cfgp.cfg.stp);                    // see [RULE1]
    end
    // flooded-frame admission only applies to the selected management port
    if (cfgp.cfg.mgmt_sel) begin                                     // see [RULE10]
      flood_ok = (frm_ucst & frm_flood & cfgp.cfg.ucst)              // see [RULE4]
               | (frm_mcst & frm_flood & cfgp.cfg.mcst)              // see [RULE6]
               | (frm_bcst & cfgp.cfg.bcst);                         // see [RULE8]
    end
    // with enables clear, only mirrored frames get through
    next_st.deliver = frm_valid & (flood_ok | frm_mirror);           // see [RULE5] [RULE7] [RULE9]
    // transmit stops only once the flush mode is also set to the stop code
    next_st.tx_en = !(cfgp.cfg.tx_off
                      && cfgp.cfg.flush_mode == `MPC_FLUSH_STOP);    // see [RULE11]
    next_st.rx_en = !cfgp.cfg.rx_off;                                // see [RULE12]
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st.deliver <= 1'b0;
      st.stp_eff <= mpc_pkg::MPC_STP_NONE;
      st.tx_en   <= 1'b1;
      st.rx_en   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign deliver = st.deliver;
  assign stp_eff = st.stp_eff;
  assign tx_en   = st.tx_en;
  assign rx_en   = st.rx_en;

endmodule

// *** mpc_apb.sv ***
// apb slave front end: one-cycle access, decode of the mapped words
// assumes an apb3 master; pready is always high in the access phase
`timescale 1ns/1ps
`include "mpc_map.svh"
module mpc_apb (
  input  wire logic        clk,       // core clock
  input  wire logic        rst_n,     // sync reset, active low
  input  wire logic        psel,      // apb select
  input  wire logic        penable,   // apb access phase
  input  wire logic        pwrite,    // apb direction
  input  wire logic [7:0]  paddr,     // apb byte address
  output logic             wr_ctrl,   // write strobe, control word
  output logic             wr_mode,   // write strobe, mode word
  output logic             wr_stat,   // write strobe, flush word
  output logic             rd_hit,    // read of a mapped word
  output logic             bad_addr   // access to an unmapped word
);

  logic acc;

  // access phase completes in its first cycle, so strobes are one pulse
  always_comb begin
    acc      = psel & penable;
    wr_ctrl  = acc & pwrite & (paddr == `MPC_OFF_CTRL);
    wr_mode  = acc & pwrite & (paddr == `MPC_OFF_MODE);
    wr_stat  = acc & pwrite & (paddr == `MPC_OFF_STATUS);
    rd_hit   = psel & !pwrite & ((paddr == `MPC_OFF_CTRL) | (paddr == `MPC_OFF_MODE)
                                 | (paddr == `MPC_OFF_STATUS));
    bad_addr = psel & !((paddr == `MPC_OFF_CTRL) | (paddr == `MPC_OFF_MODE)
                        | (paddr == `MPC_OFF_STATUS));
  end

endmodule

// *** mpc_top_assertions.sv ***
// port checker for the management port control block
// assumes binding to mpc_top; one clock MCLK, sync active-low RESET_N
`timescale 1ns/1ps
module mpc_top_checker (
  input wire logic        MCLK,          // core clock
  input wire logic        RESET_N,       // sync reset, active low
  input wire logic        PSEL,          // apb select
  input wire logic        PENABLE,       // apb access phase
  input wire logic        PWRITE,        // apb direction
  input wire logic [7:0]  PADDR,         // apb byte address
  input wire logic [31:0] PWDATA,        // apb write data
  input wire logic [31:0] PRDATA,        // apb read data
  input wire logic        PREADY,        // apb ready
  input wire logic        PSLVERR,       // apb error
  input wire logic        FRM_VALID,     // frame present
  input wire logic        FRM_UCST,      // unicast frame
  input wire logic        FRM_MCST,      // multicast frame
  input wire logic        FRM_BCST,      // broadcast frame
  input wire logic        FRM_FLOOD,     // lookup failed
  input wire logic        FRM_MIRROR,    // mirror match
  input wire logic        FRM_DELIVER,   // frame admitted
  input wire logic [2:0]  SPANNING_TREE_STATE_EFF  // effective spanning_tree_state
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  // only the three words of the map answer without error
  wire logic mapped = (PADDR == 8'h10) || (PADDR == 8'h14) || (PADDR == 8'h18);
  wire logic acc    = PSEL && PENABLE;

  // ----------------------------------------------------------------
  // bus side
  // ----------------------------------------------------------------
  chk_ready_in_access: assert property (acc |-> PREADY)
    else $error("access phase without ready");
  chk_unmapped_error: assert property (acc && !mapped |-> PSLVERR)
    else $error("unmapped access not flagged");
  chk_mapped_no_error: assert property (acc && mapped |-> !PSLVERR)
    else $error("mapped access flagged");
  chk_error_only_access: assert property (PSLVERR |-> acc)
    else $error("error outside access phase");
  chk_read_upper_zero: assert property (acc && !PWRITE |-> PRDATA[31:8] == 24'h0)
    else $error("bits above the byte read nonzero");
  chk_read_idle_zero: assert property (!PSEL |-> PRDATA == 32'h0)
    else $error("read data outside a transfer");

  // ----------------------------------------------------------------
  // frame and state side
  // ----------------------------------------------------------------
  // a reserved code written shows as the reserved state, or none when unmanaged
  chk_stp_code_range: assert property (acc && PWRITE && PADDR == 8'h10
    && PWDATA[7:5] > 3'h5 |-> ##2 (SPANNING_TREE_STATE_EFF == 3'h6 || SPANNING_TREE_STATE_EFF == 3'h0))
    else $error("reserved stp code not shown as reserved");
  chk_mirror_passes: assert property (FRM_VALID && FRM_MIRROR |=> FRM_DELIVER)
    else $error("mirrored frame dropped");
  chk_idle_no_deliver: assert property (!FRM_VALID |=> !FRM_DELIVER)
    else $error("delivery without a frame");
  chk_known_uc_dropped: assert property (FRM_VALID && FRM_UCST
    && !FRM_MCST && !FRM_BCST && !FRM_FLOOD && !FRM_MIRROR |=> !FRM_DELIVER)
    else $error("matched unicast delivered");
  chk_known_mc_dropped: assert property (FRM_VALID && FRM_MCST
    && !FRM_UCST && !FRM_BCST && !FRM_FLOOD && !FRM_MIRROR |=> !FRM_DELIVER)
    else $error("matched multicast delivered");

  // main scenarios reached
  cov_write: cover property (acc && PWRITE && mapped);
  cov_error: cover property (acc && PSLVERR);
  cov_deliver: cover property (FRM_DELIVER && !$past(FRM_MIRROR));
endmodule

bind mpc_top mpc_top_checker u_chk (
  .MCLK(MCLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .FRM_VALID(FRM_VALID), .FRM_UCST(FRM_UCST), .FRM_MCST(FRM_MCST), .FRM_BCST(FRM_BCST),
  .FRM_FLOOD(FRM_FLOOD), .FRM_MIRROR(FRM_MIRROR), .FRM_DELIVER(FRM_DELIVER),
  .SPANNING_TREE_STATE_EFF(SPANNING_TREE_STATE_EFF));

// *** mpc_top_test.sv ***
// self-checking bench for the management port control block
// assumes the apb slave answers with pready; frames checked one edge later
`timescale 1ns/1ps
`include "mpc_map.svh"
module mpc_top_test;
  logic        mclk = 1'h0;
  logic        reset_n, psel, penable, pwrite, strap, er, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, deliver, tx_en, rx_en;
  logic [5:0]  frm, f;      // valid, ucst, mcst, bcst, flood, mirror
  logic [2:0]  stp;
  int          err_total, samples_checked;

  mpc_top dut (
    .MCLK(mclk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .FORWARDING_STRAP_PIN(strap), .FRM_VALID(frm[5]), .FRM_UCST(frm[4]),
    .FRM_MCST(frm[3]), .FRM_BCST(frm[2]), .FRM_FLOOD(frm[1]), .FRM_MIRROR(frm[0]),
    .FRM_DELIVER(deliver), .SPANNING_TREE_STATE_EFF(stp), .MAC_TX_EN(tx_en), .MAC_RX_EN(rx_en));

  // 50 MHz core clock
  always #10 mclk = ~mclk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; read data and error land in rd and er
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'h1;
    @(posedge mclk);
    // no fixed latency assumed; the watchdog ends a stuck wait
    while (pready !== 1'h1) @(posedge mclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  // gated outputs follow a write one edge later; leave margin
  task settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task do_reset(input logic s);
    @(posedge mclk);
    reset_n <= 1'h0;
    strap   <= s;
    repeat (5) @(posedge mclk);
    reset_n <= 1'h1;
    repeat (2) @(posedge mclk);
    settle;
  endtask

  // qualifiers for one cycle, delivery judged at the next edge
  task frame(input logic [5:0] q, input logic x);
    @(posedge mclk);
    frm <= q;
    @(posedge mclk);
    frm <= 6'h00;
    #1;
    chk(32'(deliver), 32'(x));
  endtask

  task end_sim;
    if (err_total == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    strap = 1'h0;
    frm = 6'h00;
    err_total = 0;
    samples_checked = 0;
    // managed strap: stp disabled, mode managed, flush cleared
    do_reset(1'h0);
    apb(1'h0, `MPC_OFF_CTRL, 32'h0); chk(rd, 32'h20);
    apb(1'h0, `MPC_OFF_MODE, 32'h0); chk(rd, 32'h1);
    apb(1'h0, `MPC_OFF_STATUS, 32'h0); chk(rd, 32'h0);
    chk(32'(stp), 32'h1);
    // unmapped word: write refused, read zero with error
    apb(1'h1, 8'h1C, 32'hFF); chk(32'(er), 32'h1);
    apb(1'h0, 8'h1C, 32'h0); chk({rd[30:0], er}, 32'h1);
    // every stp code, reserved ones read back raw
    for (int c = 0; c < 8; c++) begin
      apb(1'h1, `MPC_OFF_CTRL, 32'(c << 5));
      settle;
      apb(1'h0, `MPC_OFF_CTRL, 32'h0); chk(rd, 32'(c << 5));
      chk(32'(stp), 32'((c > 5) ? 6 : c));
    end
    // unmanaged mode hides the field, software may restore managed
    apb(1'h1, `MPC_OFF_CTRL, 32'hA0);
    apb(1'h1, `MPC_OFF_MODE, 32'h0);
    settle; chk(32'(stp), 32'h0);
    apb(1'h1, `MPC_OFF_MODE, 32'h1);
    settle; chk(32'(stp), 32'h5);
    // all accept and select settings against every frame kind
    for (int c = 0; c < 16; c++) begin
      apb(1'h1, `MPC_OFF_MODE, {30'h0, c[3], 1'h1});
      apb(1'h1, `MPC_OFF_CTRL, {24'h0, 3'h5, c[2:0], 2'h0});
      settle;
      frame(6'h1F, 1'h0);
      for (int k = 0; k < 12; k++) begin
        f = {1'h1, k / 4 == 0, k / 4 == 1, k / 4 == 2, k[1], k[0]};
        e = k[0] | c[3] & (f[4] & k[1] & c[2] | f[3] & k[1] & c[1] | f[2] & c[0]);
        frame(f, e);
      end
    end
    // transmit off needs the flush setting too; receive off alone
    apb(1'h1, `MPC_OFF_CTRL, 32'hFFFFFFFF);
    settle;
    apb(1'h0, `MPC_OFF_CTRL, 32'h0); chk(rd, 32'hFF);
    chk(32'(tx_en), 32'h1);
    chk(32'(rx_en), 32'h0);
    apb(1'h1, `MPC_OFF_STATUS, {24'h0, `MPC_FLUSH_STOP});
    settle; chk(32'(tx_en), 32'h0);
    apb(1'h1, `MPC_OFF_CTRL, 32'h0);
    settle; chk({tx_en, rx_en}, 32'h3);
    // second reset mid-run, unmanaged strap
    do_reset(1'h1);
    apb(1'h0, `MPC_OFF_CTRL, 32'h0); chk(rd, 32'h0);
    apb(1'h0, `MPC_OFF_MODE, 32'h0); chk(rd, 32'h0);
    apb(1'h0, `MPC_OFF_STATUS, 32'h0); chk(rd, 32'h0);
    chk(32'(stp), 32'h0);
    end_sim;
  end

  // watchdog well beyond the under a thousand cycles the tests need
  initial begin
    #400000;
    err_total++;
    end_sim;
  end
endmodule
